// >>> rtl/tcc_core.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Key is non-touch while its variance is below the threshold; unit 60 fF.
// - Tracking wait equals programmed 8-bit value times 64 sensor clock periods.
// - Wait starts when all twelve keys first return to non-touch.
// - Calibration fires only after non-touch held for the whole wait.
// - Baseline offset is 7 bits, bit 7 reserved, values 0 to 127.
// - Each baseline offset unit is one 60 pF reference step.
// - New baseline offset takes effect only after a warm reset.
// - Each key compares its variance against its own 7-bit touch margin.
module tcc_core
	import tcc_pkg::*;
#(
	parameter int unsigned NKEYS = TCC_KEYS
)
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sensor_tick,
	input wire logic warm_reset,
	input wire logic [NKEYS*TCC_VAR_W-1:0] key_variance,
	input wire logic [NKEYS*TCC_VAR_W-1:0] touch_sensitivity_margin,
	output logic [NKEYS-1:0] key_nontouch,
	output logic [NKEYS-1:0] key_touch,
	output logic tracking_cal_start,
	output logic [6:0] applied_offset_steps
);
	logic [6:0] thresh_q, thresh_d;
	logic [7:0] wait_q, wait_d;
	logic [6:0] offset_q, offset_d;
	logic [6:0] applied_q, applied_d;
	logic [7:0] rdata_q, rdata_d;
	logic [NKEYS-1:0] nontouch_q, nontouch_d;
	logic [NKEYS-1:0] touch_q, touch_d;
	tcc_state_e state_q, state_d;
	logic [TCC_CNT_W-1:0] cnt_q, cnt_d;
	logic cal_q, cal_d;
	logic all_nt;
	logic [TCC_CNT_W-1:0] target;

	// Register file
	always_comb
	begin
		thresh_d = thresh_q;
		wait_d = wait_q;
		offset_d = offset_q;
		applied_d = applied_q;
		if (reg_wr)
		begin
			case (reg_addr)
				TCC_ADDR_THRESH: thresh_d = reg_wdata[6:0];
				TCC_ADDR_WAIT: wait_d = reg_wdata;
				TCC_ADDR_OFFSET: offset_d = reg_wdata[6:0];
				default: ;
			endcase
		end
		if (warm_reset)
			applied_d = offset_q;
		case (reg_addr)
			TCC_ADDR_THRESH: rdata_d = {1'h0, thresh_q};
			TCC_ADDR_WAIT: rdata_d = wait_q;
			TCC_ADDR_OFFSET: rdata_d = {1'h0, offset_q};
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			thresh_q <= TCC_THRESH_RESET;
			wait_q <= TCC_WAIT_RESET;
			offset_q <= TCC_OFFSET_RESET;
			applied_q <= TCC_OFFSET_RESET;
			rdata_q <= 8'h00;
		end
		else
		begin
			thresh_q <= thresh_d;
			wait_q <= wait_d;
			offset_q <= offset_d;
			applied_q <= applied_d;
			rdata_q <= rdata_d;
		end
	end

	// Per-key classification
	always_comb
	begin
		for (int i = 0; i < NKEYS; i++)
		begin
			nontouch_d[i] = key_variance[i*TCC_VAR_W +: TCC_VAR_W] < thresh_q;
			touch_d[i] = key_variance[i*TCC_VAR_W +: TCC_VAR_W]
				>= touch_sensitivity_margin[i*TCC_VAR_W +: TCC_VAR_W];
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			nontouch_q <= '0;
			touch_q <= '0;
		end
		else
		begin
			nontouch_q <= nontouch_d;
			touch_q <= touch_d;
		end
	end

	assign all_nt = &nontouch_q;
	assign target = {wait_q, {TCC_WAIT_SCALE_LOG2{1'h0}}};

	// Tracking calibration timer, counts sensor clock ticks
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		cal_d = 1'h0;
		case (state_q)
			TCC_ARMED:
			begin
				cnt_d = '0;
				if (all_nt)
					state_d = TCC_COUNT;
			end
			TCC_COUNT:
			begin
				if (!all_nt)
				begin
					state_d = TCC_ARMED;
					cnt_d = '0;
				end
				else if (cnt_q >= target)
				begin
					cal_d = 1'h1;
					state_d = TCC_DONE;
				end
				else if (sensor_tick)
					cnt_d = cnt_q + TCC_CNT_W'(1);
			end
			TCC_DONE:
			begin
				cnt_d = '0;
				if (!all_nt)
					state_d = TCC_ARMED;
			end
			default:
			begin
				state_d = TCC_ARMED;
				cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			state_q <= TCC_ARMED;
			cnt_q <= '0;
			cal_q <= 1'h0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			cal_q <= cal_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign key_nontouch = nontouch_q;
	assign key_touch = touch_q;
	assign tracking_cal_start = cal_q;
	assign applied_offset_steps = applied_q;

	chk_thresh_used: assert property (@(posedge clock) disable iff (!rstn)
		(key_variance[TCC_VAR_W-1:0] < thresh_q) |=> key_nontouch[0])
		else $error("key 0 below threshold not marked non-touch");
	chk_touch_cmp: assert property (@(posedge clock) disable iff (!rstn)
		(key_variance[TCC_VAR_W-1:0] >= touch_sensitivity_margin[TCC_VAR_W-1:0])
		|=> key_touch[0])
		else $error("key 0 at margin not marked touched");
	chk_wait_start: assert property (@(posedge clock) disable iff (!rstn)
		(state_q == TCC_ARMED && all_nt) |=> (state_q == TCC_COUNT && cnt_q == '0))
		else $error("wait did not start when all keys cleared");
	chk_wait_length: assert property (@(posedge clock) disable iff (!rstn)
		$rose(tracking_cal_start) |-> $past(cnt_q) == target)
		else $error("calibration fired at wrong count");
	chk_no_early: assert property (@(posedge clock) disable iff (!rstn)
		tracking_cal_start |-> $past(all_nt) && $past(state_q) == TCC_COUNT)
		else $error("calibration without sustained non-touch");
	chk_abandon_wait: assert property (@(posedge clock) disable iff (!rstn)
		(state_q == TCC_COUNT && !all_nt) |=> (state_q == TCC_ARMED && !tracking_cal_start))
		else $error("touch during wait did not abandon it");
	chk_rsvd_zero: assert property (@(posedge clock) disable iff (!rstn)
		(reg_addr == TCC_ADDR_OFFSET) |=> (reg_rdata[7] == 1'h0))
		else $error("reserved offset bit read nonzero");
	chk_offset_hold: assert property (@(posedge clock) disable iff (!rstn)
		(applied_offset_steps != $past(applied_offset_steps))
		|-> ($past(warm_reset) || !$past(rstn)))
		else $error("offset applied without warm reset");
	chk_warm_apply: assert property (@(posedge clock) disable iff (!rstn)
		warm_reset |=> (applied_offset_steps == $past(offset_q)))
		else $error("warm reset did not apply stored offset");
	chk_wait_write: assert property (@(posedge clock) disable iff (!rstn)
		(reg_wr && reg_addr == TCC_ADDR_WAIT) |=> (wait_q == $past(reg_wdata)))
		else $error("wait time write did not land");
	chk_count_tick: assert property (@(posedge clock) disable iff (!rstn)
		(state_q == TCC_COUNT && all_nt && cnt_q < target && !sensor_tick)
		|=> (cnt_q == $past(cnt_q)))
		else $error("wait counter moved without a sensor tick");
	chk_cal_pulse: assert property (@(posedge clock) disable iff (!rstn)
		tracking_cal_start |=> !tracking_cal_start)
		else $error("calibration pulse longer than one cycle");

	// At least one key to watch
	if (NKEYS < 1)
	begin : g_bad_keys
		$error("NKEYS must be at least one");
	end
endmodule // tcc_core
`default_nettype wire

// >>> rtl/tcc_pkg.sv
package tcc_pkg;
	localparam int unsigned TCC_KEYS = 12;
	localparam int unsigned TCC_VAR_W = 7;
	localparam logic [7:0] TCC_ADDR_THRESH = 8'h0d;
	localparam logic [7:0] TCC_ADDR_WAIT = 8'h0e;
	localparam logic [7:0] TCC_ADDR_OFFSET = 8'h0f;
	localparam logic [6:0] TCC_THRESH_RESET = 7'h04;
	localparam logic [7:0] TCC_WAIT_RESET = 8'h27;
	localparam logic [6:0] TCC_OFFSET_RESET = 7'h00;
	localparam int unsigned TCC_WAIT_SCALE_LOG2 = 6;
	localparam int unsigned TCC_CNT_W = 8 + TCC_WAIT_SCALE_LOG2;
	localparam int unsigned TCC_STEP_THRESH_FF = 60;
	localparam int unsigned TCC_STEP_OFFSET_PF = 60;
	typedef enum logic [2:0] {
		TCC_ARMED = 3'h1,
		TCC_COUNT = 3'h2,
		TCC_DONE = 3'h4
	} tcc_state_e;
endpackage

// >>> dv/tcc_host.sv
`timescale 1ns/1ns
`default_nettype none
module tcc_host
(
	input wire logic clock,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wr = 1'h0;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge clock);
		reg_wr = 1'h0;
		// Idle cycle so a following write never re-raises the strobe at once
		@(negedge clock);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		@(negedge clock);
		d = reg_rdata;
	endtask
endmodule // tcc_host
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
	import tcc_pkg::*;
;
	logic clock = 1'h0;
	logic rstn = 1'h0;
	logic warm_reset = 1'h0;
	logic tick = 1'h1;
	logic [83:0] kv = {12{7'h7f}};
	logic [83:0] tsm = {12{7'h08}};
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic reg_wr, cal;
	logic [11:0] nt, tch;
	logic [6:0] ofs;
	int n_errors = 0;
	int n_tests = 0;
	int n;
	initial forever #4 clock = ~clock;
	tcc_host hst (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata));
	tcc_core dut_u (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sensor_tick(tick),
		.warm_reset(warm_reset), .key_variance(kv),
		.touch_sensitivity_margin(tsm), .key_nontouch(nt), .key_touch(tch),
		.tracking_cal_start(cal), .applied_offset_steps(ofs));
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic t_regs;
		hst.rd(TCC_ADDR_THRESH, d);
		chk(12'(d), 12'h004);
		hst.rd(TCC_ADDR_WAIT, d);
		chk(12'(d), 12'h027);
		hst.rd(8'h10, d);
		chk(12'(d), 12'h000);
		hst.wr(TCC_ADDR_OFFSET, 8'hff);
		hst.rd(TCC_ADDR_OFFSET, d);
		chk(12'(d), 12'h07f);
		chk(12'(ofs), 12'h000);
		warm_reset = 1'h1;
		@(negedge clock);
		warm_reset = 1'h0;
		chk(12'(ofs), 12'h07f);
		// Mid-run reset drops both stored and applied offset
		rstn = 1'h0;
		@(negedge clock);
		rstn = 1'h1;
		chk(12'(ofs), 12'h000);
		hst.rd(TCC_ADDR_OFFSET, d);
		chk(12'(d), 12'h000);
	endtask
	task automatic t_detect;
		hst.wr(TCC_ADDR_THRESH, 8'h05);
		kv = {12{7'h04}};
		kv[27:21] = 7'h05;
		kv[20:14] = 7'h0c;
		kv[6:0] = 7'h09;
		tsm[20:14] = 7'h0c;
		tsm[6:0] = 7'h0a;
		@(negedge clock);
		chk(nt, 12'hff2);
		chk(tch, 12'h004);
	endtask
	task automatic t_timer;
		hst.wr(TCC_ADDR_WAIT, 8'h01);
		kv = {12{7'h01}};
		repeat (30)
		begin
			@(negedge clock);
			chk(12'(cal), 12'h000);
		end
		kv[6:0] = 7'h7f;
		repeat (2) @(negedge clock);
		kv[6:0] = 7'h01;
		n = 0;
		while (cal !== 1'h1 && n < 200)
		begin
			@(negedge clock);
			n++;
		end
		chk(12'(n), 12'((1 << TCC_WAIT_SCALE_LOG2) + 3));
		@(negedge clock);
		chk(12'(cal), 12'h000);
	endtask
	task automatic t_tick;
		tick = 1'h0;
		kv[6:0] = 7'h7f;
		repeat (2) @(negedge clock);
		kv[6:0] = 7'h01;
		repeat (100)
		begin
			@(negedge clock);
			chk(12'(cal), 12'h000);
		end
		tick = 1'h1;
		n = 0;
		while (cal !== 1'h1 && n < 200)
		begin
			@(negedge clock);
			n++;
		end
		chk(12'(n), 12'((1 << TCC_WAIT_SCALE_LOG2) + 1));
	endtask
	initial
	begin
		repeat (20) @(negedge clock);
		rstn = 1'h1;
		t_regs();
		t_detect();
		t_timer();
		t_tick();
		end_of_test();
	end
	initial
	begin
		#20000;
		n_errors++;
		end_of_test();
	end
endmodule // tb
`default_nettype wire
